/* include/pcm_pkg.sv */
// Shared constants and types for the clock generator configuration and pin mux block.
package pcm_pkg;
  // Array shape of the stored configurations.
  localparam int NUM_LOOPS = 3;
  localparam int NUM_CFG = 4;
  localparam int NUM_PINS = 6;
  // Feedback divider field widths.
  localparam int FB_INT_W = 12;
  localparam int FB_ADD_W = 4;
  localparam int FRAC_W = 6;
  localparam int STEP_W = 4;
  localparam int DELTA_W = 4;
  localparam int NUM_DELTA = 12;
  localparam int MULT_W = FB_INT_W + 2 + FRAC_W;
  // Loop filter code widths.
  localparam int RZ_W = 4;
  localparam int CZ_W = 4;
  localparam int CP_W = 4;
  localparam int IP_W = 3;
  // Zero capacitor in tenths of a picofarad: base 6.0 pF, step 27.2 pF.
  localparam int CAP_W = 16;
  localparam logic [CAP_W-1:0] ZCAP_BASE_DPF = 16'h003C;
  localparam logic [CAP_W-1:0] ZCAP_STEP_DPF = 16'h0110;
  // Charge pump current in microamps: 5 uA times a power of two, up to 640 uA.
  localparam int PUMP_W = 10;
  localparam logic [PUMP_W-1:0] PUMP_BASE_UA = 10'h005;
  localparam logic [PUMP_W-1:0] PUMP_MAX_UA = 10'h280;
  // Only the first two loops have a fractional feedback path.
  localparam logic [NUM_LOOPS-1:0] LOOP_FRAC_CAPABLE = 3'h3;
  // Encoding of the tri-level interface select pad sensor.
  localparam logic [1:0] IFSEL_LOW = 2'h0;
  localparam logic [1:0] IFSEL_HIGH = 2'h1;
  localparam logic [1:0] IFSEL_FLOAT = 2'h2;
  // Cycles after reset release before the power-up selection is latched.
  localparam logic [1:0] BOOT_LATCH_CYCLES = 2'h3;
  // Scan data register width.
  localparam int SCAN_W = 8;
  typedef enum logic [1:0] {MODE_MFC_SINGLE, MODE_MFC_ALL, MODE_I2C, MODE_JTAG} pcm_mode_t;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } pcm_tap_t;
endpackage

/* src/pcm_config_mux.sv */
// Mode decode, multi-purpose pin routing, configuration selection and scan port of the clock generator.
`timescale 1ns/1ps
module pcm_config_mux (
  // Clocks and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic scan_clk_in,
  // Multi-purpose pins
  input wire logic multi_in_0,
  input wire logic multi_in_1,
  input wire logic multi_in_2,
  input wire logic multi_in_3,
  input wire logic multi_in_4,
  input wire logic multi_in_5,
  input wire logic [1:0] iface_sel_in,
  output logic multi_out_0,
  output logic multi_out_1,
  // Internal control and status
  input wire logic freq_select_mode_bit_in,
  input wire logic primary_clock_select_in,
  input wire logic lock_lost_flag_in,
  input wire logic primary_clock_lost_flag_in,
  // Stored configurations
  input wire logic [pcm_pkg::FB_INT_W-1:0] fb_int_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic [pcm_pkg::FB_ADD_W-1:0] fb_add_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic [pcm_pkg::FRAC_W-1:0] fraction_offset_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic [pcm_pkg::STEP_W-1:0] modulation_step_count_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic [pcm_pkg::NUM_DELTA*pcm_pkg::DELTA_W-1:0] profile_delta_samples_in
    [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic [pcm_pkg::RZ_W-1:0] loop_resistor_code_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic [pcm_pkg::CZ_W-1:0] zero_cap_code_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic [pcm_pkg::CP_W-1:0] pole_cap_code_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic [pcm_pkg::IP_W-1:0] pump_current_code_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  input wire logic odiv_sel_in [pcm_pkg::NUM_LOOPS][pcm_pkg::NUM_CFG],
  // Mode and routed pin functions
  output pcm_pkg::pcm_mode_t mode_out,
  output logic i2c_sda_out,
  output logic i2c_scl_out,
  output logic output_hold_out,
  output logic ref_alternate_out,
  // Active loop settings
  output logic [2:0] cfg_index_out [pcm_pkg::NUM_LOOPS],
  output logic [pcm_pkg::MULT_W-1:0] mult_out [pcm_pkg::NUM_LOOPS],
  output logic frac_mode_out [pcm_pkg::NUM_LOOPS],
  output logic ss_enable_out [pcm_pkg::NUM_LOOPS],
  output logic odiv_out [pcm_pkg::NUM_LOOPS],
  output logic [pcm_pkg::RZ_W-1:0] loop_resistor_code_out [pcm_pkg::NUM_LOOPS],
  output logic [pcm_pkg::CZ_W-1:0] zero_cap_code_out [pcm_pkg::NUM_LOOPS],
  output logic [pcm_pkg::CP_W-1:0] pole_cap_code_out [pcm_pkg::NUM_LOOPS],
  output logic [pcm_pkg::IP_W-1:0] pump_current_code_out [pcm_pkg::NUM_LOOPS],
  output logic [pcm_pkg::CAP_W-1:0] zero_cap_dpf_out [pcm_pkg::NUM_LOOPS],
  output logic [pcm_pkg::PUMP_W-1:0] pump_ua_out [pcm_pkg::NUM_LOOPS]
);

  // The fractional path is a modulator with no step shaping.
  function automatic logic frac_active(input logic [pcm_pkg::STEP_W-1:0] steps,
                                       input logic [pcm_pkg::NUM_DELTA*pcm_pkg::DELTA_W-1:0] deltas);
    frac_active = (steps != '0) && (deltas == '0);
  endfunction

  function automatic logic [pcm_pkg::MULT_W-1:0] calc_mult(input logic [pcm_pkg::FB_INT_W-1:0] n,
                                                           input logic [pcm_pkg::FB_ADD_W-1:0] a,
                                                           input logic [pcm_pkg::FRAC_W-1:0] f,
                                                           input logic use_frac);
    logic [pcm_pkg::MULT_W-1:0] whole;
    whole = {{(pcm_pkg::MULT_W-pcm_pkg::FB_INT_W-1){1'b0}}, n, 1'b0}
      + {{(pcm_pkg::MULT_W-pcm_pkg::FB_ADD_W){1'b0}}, a}
      + {{(pcm_pkg::MULT_W-1){1'b0}}, 1'b1};
    calc_mult = (whole << pcm_pkg::FRAC_W)
      + (use_frac ? {{(pcm_pkg::MULT_W-pcm_pkg::FRAC_W){1'b0}}, f} : '0);
  endfunction

  function automatic pcm_pkg::pcm_tap_t tap_next(input pcm_pkg::pcm_tap_t s, input logic tms);
    case (s)
      pcm_pkg::TAP_RESET: tap_next = tms ? pcm_pkg::TAP_RESET : pcm_pkg::TAP_IDLE;
      pcm_pkg::TAP_IDLE: tap_next = tms ? pcm_pkg::TAP_SEL_DR : pcm_pkg::TAP_IDLE;
      pcm_pkg::TAP_SEL_DR: tap_next = tms ? pcm_pkg::TAP_SEL_IR : pcm_pkg::TAP_CAP_DR;
      pcm_pkg::TAP_CAP_DR: tap_next = tms ? pcm_pkg::TAP_EXIT1_DR : pcm_pkg::TAP_SHIFT_DR;
      pcm_pkg::TAP_SHIFT_DR: tap_next = tms ? pcm_pkg::TAP_EXIT1_DR : pcm_pkg::TAP_SHIFT_DR;
      pcm_pkg::TAP_EXIT1_DR: tap_next = tms ? pcm_pkg::TAP_UPD_DR : pcm_pkg::TAP_PAUSE_DR;
      pcm_pkg::TAP_PAUSE_DR: tap_next = tms ? pcm_pkg::TAP_EXIT2_DR : pcm_pkg::TAP_PAUSE_DR;
      pcm_pkg::TAP_EXIT2_DR: tap_next = tms ? pcm_pkg::TAP_UPD_DR : pcm_pkg::TAP_SHIFT_DR;
      pcm_pkg::TAP_UPD_DR: tap_next = tms ? pcm_pkg::TAP_SEL_DR : pcm_pkg::TAP_IDLE;
      pcm_pkg::TAP_SEL_IR: tap_next = tms ? pcm_pkg::TAP_RESET : pcm_pkg::TAP_CAP_IR;
      pcm_pkg::TAP_CAP_IR: tap_next = tms ? pcm_pkg::TAP_EXIT1_IR : pcm_pkg::TAP_SHIFT_IR;
      pcm_pkg::TAP_SHIFT_IR: tap_next = tms ? pcm_pkg::TAP_EXIT1_IR : pcm_pkg::TAP_SHIFT_IR;
      pcm_pkg::TAP_EXIT1_IR: tap_next = tms ? pcm_pkg::TAP_UPD_IR : pcm_pkg::TAP_PAUSE_IR;
      pcm_pkg::TAP_PAUSE_IR: tap_next = tms ? pcm_pkg::TAP_EXIT2_IR : pcm_pkg::TAP_PAUSE_IR;
      pcm_pkg::TAP_EXIT2_IR: tap_next = tms ? pcm_pkg::TAP_UPD_IR : pcm_pkg::TAP_SHIFT_IR;
      pcm_pkg::TAP_UPD_IR: tap_next = tms ? pcm_pkg::TAP_SEL_DR : pcm_pkg::TAP_IDLE;
      default: tap_next = pcm_pkg::TAP_RESET;
    endcase
  endfunction

  // Pin synchronisers; only the second stage is read.
  logic [pcm_pkg::NUM_PINS+1:0] pin_raw;
  logic [pcm_pkg::NUM_PINS+1:0] pin_s1_q;
  logic [pcm_pkg::NUM_PINS+1:0] pin_s2_q;
  assign pin_raw = {iface_sel_in, multi_in_5, multi_in_4, multi_in_3, multi_in_2, multi_in_1, multi_in_0};

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // The select pad resets as floating, so no false scan mode shows before the first real sample.
      pin_s1_q <= {pcm_pkg::IFSEL_FLOAT, {pcm_pkg::NUM_PINS{1'b0}}};
      pin_s2_q <= {pcm_pkg::IFSEL_FLOAT, {pcm_pkg::NUM_PINS{1'b0}}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Mode decode.
  pcm_pkg::pcm_mode_t mode_d;
  pcm_pkg::pcm_mode_t mode_q;
  always_comb begin
    case (pin_s2_q[pcm_pkg::NUM_PINS+1:pcm_pkg::NUM_PINS])
      pcm_pkg::IFSEL_LOW: mode_d = pcm_pkg::MODE_JTAG;
      pcm_pkg::IFSEL_HIGH: mode_d = pcm_pkg::MODE_I2C;
      default: mode_d = freq_select_mode_bit_in ? pcm_pkg::MODE_MFC_SINGLE : pcm_pkg::MODE_MFC_ALL;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_q <= pcm_pkg::MODE_MFC_ALL;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Power-up selection latch. The pins are latched once the synchronisers hold real samples, so a
  // later change of interface mode cannot switch configurations behind the host's back.
  logic [1:0] boot_cnt_q;
  logic [4:0] boot_sel_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_cnt_q <= '0;
      boot_sel_q <= '0;
    end else if (boot_cnt_q != pcm_pkg::BOOT_LATCH_CYCLES) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
      boot_sel_q <= pin_s2_q[4:0];
    end
  end

  // Configuration selection and source lookup.
  logic manual_mode;
  logic [pcm_pkg::NUM_PINS-1:0] sel_pins;
  logic [2:0] cfg_idx [pcm_pkg::NUM_LOOPS];
  logic [1:0] src_loop [pcm_pkg::NUM_LOOPS];
  logic [1:0] src_cfg [pcm_pkg::NUM_LOOPS];
  assign manual_mode = (mode_q == pcm_pkg::MODE_MFC_SINGLE) || (mode_q == pcm_pkg::MODE_MFC_ALL);
  assign sel_pins = manual_mode ? pin_s2_q[pcm_pkg::NUM_PINS-1:0] : {1'b0, boot_sel_q};

  always_comb begin
    for (int l = 0; l < pcm_pkg::NUM_LOOPS; l++) begin
      src_loop[l] = 2'(l);
      if (mode_q == pcm_pkg::MODE_MFC_SINGLE) begin
        cfg_idx[l] = (l == 0) ? sel_pins[2:0] : 3'h0;
      end else begin
        cfg_idx[l] = {1'b0, sel_pins[2*l+1], sel_pins[2*l]};
      end
      src_cfg[l] = cfg_idx[l][1:0];
      // Upper four single-loop configurations borrow the spare sets of the other loops.
      if (cfg_idx[l][2]) begin
        src_loop[l] = cfg_idx[l][1] ? 2'h2 : 2'h1;
        src_cfg[l] = {1'b1, cfg_idx[l][0]};
      end
    end
  end

  // Active loop settings.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int l = 0; l < pcm_pkg::NUM_LOOPS; l++) begin
        cfg_index_out[l] <= '0;
        mult_out[l] <= '0;
        frac_mode_out[l] <= 1'b0;
        ss_enable_out[l] <= 1'b0;
        odiv_out[l] <= 1'b0;
        loop_resistor_code_out[l] <= '0;
        zero_cap_code_out[l] <= '0;
        pole_cap_code_out[l] <= '0;
        pump_current_code_out[l] <= '0;
        zero_cap_dpf_out[l] <= pcm_pkg::ZCAP_BASE_DPF;
        pump_ua_out[l] <= pcm_pkg::PUMP_BASE_UA;
      end
    end else begin
      for (int l = 0; l < pcm_pkg::NUM_LOOPS; l++) begin
        automatic logic fr;
        fr = pcm_pkg::LOOP_FRAC_CAPABLE[l]
          && frac_active(modulation_step_count_in[src_loop[l]][src_cfg[l]],
                         profile_delta_samples_in[src_loop[l]][src_cfg[l]]);
        cfg_index_out[l] <= cfg_idx[l];
        frac_mode_out[l] <= fr;
        mult_out[l] <= calc_mult(fb_int_in[src_loop[l]][src_cfg[l]], fb_add_in[src_loop[l]][src_cfg[l]],
                                 fraction_offset_in[src_loop[l]][src_cfg[l]], fr);
        ss_enable_out[l] <= pcm_pkg::LOOP_FRAC_CAPABLE[l] && !fr
          && (modulation_step_count_in[src_loop[l]][src_cfg[l]] != '0);
        odiv_out[l] <= odiv_sel_in[src_loop[l]][src_cfg[l]];
        loop_resistor_code_out[l] <= loop_resistor_code_in[src_loop[l]][src_cfg[l]];
        zero_cap_code_out[l] <= zero_cap_code_in[src_loop[l]][src_cfg[l]];
        pole_cap_code_out[l] <= pole_cap_code_in[src_loop[l]][src_cfg[l]];
        pump_current_code_out[l] <= pump_current_code_in[src_loop[l]][src_cfg[l]];
        zero_cap_dpf_out[l] <= pcm_pkg::ZCAP_BASE_DPF
          + pcm_pkg::ZCAP_STEP_DPF * {{(pcm_pkg::CAP_W-pcm_pkg::CZ_W){1'b0}},
                                      zero_cap_code_in[src_loop[l]][src_cfg[l]]};
        pump_ua_out[l] <= pcm_pkg::PUMP_BASE_UA << pump_current_code_in[src_loop[l]][src_cfg[l]];
      end
    end
  end

  // Scan link domain. The scan reset pin acts without the scan clock, which may stand still.
  logic scan_rst_n;
  logic jmode_s1_q;
  logic jmode_s2_q;
  logic [1:0] stat_s1_q;
  logic [1:0] stat_s2_q;
  pcm_pkg::pcm_tap_t tap_q;
  logic [pcm_pkg::SCAN_W-1:0] scan_dr_q;
  logic scan_tdo_q;
  assign scan_rst_n = nrst_in & multi_in_4;

  always_ff @(posedge scan_clk_in or negedge scan_rst_n) begin
    if (!scan_rst_n) begin
      jmode_s1_q <= 1'b0;
      jmode_s2_q <= 1'b0;
      stat_s1_q <= '0;
      stat_s2_q <= '0;
    end else begin
      jmode_s1_q <= (mode_q == pcm_pkg::MODE_JTAG);
      jmode_s2_q <= jmode_s1_q;
      stat_s1_q <= {lock_lost_flag_in, primary_clock_lost_flag_in};
      stat_s2_q <= stat_s1_q;
    end
  end

  // Outside the scan mode the controller is parked in its reset state.
  always_ff @(posedge scan_clk_in or negedge scan_rst_n) begin
    if (!scan_rst_n) begin
      tap_q <= pcm_pkg::TAP_RESET;
    end else begin
      tap_q <= jmode_s2_q ? tap_next(tap_q, multi_in_2) : pcm_pkg::TAP_RESET;
    end
  end

  always_ff @(posedge scan_clk_in or negedge scan_rst_n) begin
    if (!scan_rst_n) begin
      scan_dr_q <= '0;
      scan_tdo_q <= 1'b0;
    end else if (tap_q == pcm_pkg::TAP_CAP_DR) begin
      scan_dr_q <= {{(pcm_pkg::SCAN_W-2){1'b0}}, stat_s2_q};
    end else if (tap_q == pcm_pkg::TAP_SHIFT_DR) begin
      scan_dr_q <= {multi_in_0, scan_dr_q[pcm_pkg::SCAN_W-1:1]};
      scan_tdo_q <= scan_dr_q[0];
    end
  end

  // Scan data out returns to the system clock as a level.
  logic tdo_s1_q;
  logic tdo_s2_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tdo_s1_q <= 1'b0;
      tdo_s2_q <= 1'b0;
    end else begin
      tdo_s1_q <= scan_tdo_q;
      tdo_s2_q <= tdo_s1_q;
    end
  end

  // Pin function routing. Unused functions idle at their inactive level.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      multi_out_0 <= 1'b0;
      multi_out_1 <= 1'b0;
      i2c_sda_out <= 1'b1;
      i2c_scl_out <= 1'b1;
      output_hold_out <= 1'b0;
      ref_alternate_out <= 1'b0;
    end else begin
      multi_out_0 <= (mode_q == pcm_pkg::MODE_JTAG) ? tdo_s2_q : lock_lost_flag_in;
      multi_out_1 <= primary_clock_lost_flag_in;
      i2c_sda_out <= (mode_q == pcm_pkg::MODE_I2C) ? pin_s2_q[0] : 1'b1;
      i2c_scl_out <= (mode_q == pcm_pkg::MODE_I2C) ? pin_s2_q[1] : 1'b1;
      output_hold_out <= (mode_q != pcm_pkg::MODE_MFC_ALL) && pin_s2_q[3];
      ref_alternate_out <= (mode_q == pcm_pkg::MODE_MFC_ALL) ? primary_clock_select_in : pin_s2_q[5];
    end
  end

  assign mode_out = mode_q;

  chk_loop2_integer: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !frac_mode_out[2] && !ss_enable_out[2]) else $error("third loop left integer mode");
  chk_frac_low_bits: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !frac_mode_out[0] |-> mult_out[0][pcm_pkg::FRAC_W-1:0] == '0) else $error("fraction leaked");
  chk_mult_odd_base: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 mult_out[1][pcm_pkg::FRAC_W] != $past(fb_add_in[1][src_cfg[1]][0], 1)
      || $past(mode_q) == pcm_pkg::MODE_MFC_SINGLE) else $error("multiplier parity wrong");
  chk_frac_no_ss: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(frac_mode_out[0] && ss_enable_out[0]) && !(frac_mode_out[1] && ss_enable_out[1]))
    else $error("modulation active in fractional mode");
  chk_zcap_value: assert property (@(posedge clk_in) disable iff (!nrst_in)
    zero_cap_dpf_out[0] == pcm_pkg::ZCAP_BASE_DPF + pcm_pkg::ZCAP_STEP_DPF * zero_cap_code_out[0])
    else $error("zero capacitor value wrong");
  chk_pump_range: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pump_ua_out[1] >= pcm_pkg::PUMP_BASE_UA && pump_ua_out[1] <= pcm_pkg::PUMP_MAX_UA
      && pump_ua_out[1] == (pcm_pkg::PUMP_BASE_UA << pump_current_code_out[1])) else $error("pump current wrong");
  chk_mode_decode: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pin_s2_q[7:6] == pcm_pkg::IFSEL_LOW |=> mode_q == pcm_pkg::MODE_JTAG) else $error("scan mode not entered");
  chk_mode_float: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pin_s2_q[7:6] == pcm_pkg::IFSEL_FLOAT && freq_select_mode_bit_in |=> mode_q == pcm_pkg::MODE_MFC_SINGLE)
    else $error("single loop mode not entered");
  chk_out0_route: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mode_q != pcm_pkg::MODE_JTAG |=> multi_out_0 == $past(lock_lost_flag_in)) else $error("lock loss not routed");
  chk_out1_route: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 multi_out_1 == $past(primary_clock_lost_flag_in)) else $error("clock loss not routed");
  chk_hold_route: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mode_q == pcm_pkg::MODE_I2C && pin_s2_q[3] |=> output_hold_out) else $error("hold not applied");
  chk_tap_park: assert property (@(posedge scan_clk_in) disable iff (!scan_rst_n)
    tap_q == pcm_pkg::TAP_RESET && multi_in_2 |=> tap_q == pcm_pkg::TAP_RESET) else $error("TAP left reset");

endmodule

/* tb/pcm_host_model.sv */
// Host controller model driving the multi-purpose pins and the scan port.
`timescale 1ns/1ps
module pcm_host_model (
  // Pin drive
  output logic [5:0] pins_out,
  output logic [1:0] iface_out,
  // Pin return
  input wire logic scan_out_in
);
  initial begin
    pins_out = 6'h00;
    iface_out = 2'h2;
  end
  // Static pin levels; bit 1 of p drives the scan clock pin between frames.
  task automatic set_pins(input logic [5:0] p, input logic [1:0] s);
    pins_out = p;
    iface_out = s;
  endtask
  // Walk to data shift, then 17 shift edges; a sample is taken 5 ns after each of the last 16 rises.
  // Unused data edges toggle, so a stale level is never mistaken for a real bit.
  task automatic scan_frame(input logic [7:0] tdi, output logic [15:0] seen);
    for (int e = 0; e < 24; e++) begin
      pins_out[2] = (e == 4);
      pins_out[0] = (e >= 7 && e < 15) ? tdi[e-7] : ~pins_out[0];
      #7.5 pins_out[1] = 1'b1;
      #5 if (e >= 8) seen[e-8] = scan_out_in;
      #2.5 pins_out[1] = 1'b0;
    end
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the configuration pin mux.
`timescale 1ns/1ps
module tb_top;
  localparam int L = 3;
  localparam int C = 4;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic mbit = 1'b0;
  logic psel = 1'b0;
  logic lock = 1'b0;
  logic plost = 1'b0;
  logic [5:0] pins;
  logic [1:0] iface;
  logic mo0, mo1, sda, scl, hold, ralt;
  pcm_pkg::pcm_mode_t mode;
  logic [11:0] fbi [L][C];
  logic [3:0] fba [L][C], stp [L][C], rz [L][C], cz [L][C], cp [L][C];
  logic [5:0] fof [L][C];
  logic [47:0] dl [L][C];
  logic [2:0] ip [L][C];
  logic od [L][C];
  logic [2:0] idx_o [L], ip_o [L];
  logic [19:0] mul_o [L];
  logic fr_o [L], ss_o [L], od_o [L];
  logic [3:0] rz_o [L], cz_o [L], cp_o [L];
  logic [15:0] zc_o [L];
  logic [9:0] pu_o [L];
  logic [15:0] seen;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  pcm_host_model host (.pins_out(pins), .iface_out(iface), .scan_out_in(mo0));
  pcm_config_mux dut (.clk_in(clk_in), .nrst_in(nrst_in), .scan_clk_in(pins[1]), .multi_in_0(pins[0]),
    .multi_in_1(pins[1]), .multi_in_2(pins[2]), .multi_in_3(pins[3]), .multi_in_4(pins[4]), .multi_in_5(pins[5]),
    .iface_sel_in(iface), .multi_out_0(mo0), .multi_out_1(mo1), .freq_select_mode_bit_in(mbit),
    .primary_clock_select_in(psel), .lock_lost_flag_in(lock), .primary_clock_lost_flag_in(plost),
    .fb_int_in(fbi), .fb_add_in(fba), .fraction_offset_in(fof), .modulation_step_count_in(stp),
    .profile_delta_samples_in(dl), .loop_resistor_code_in(rz), .zero_cap_code_in(cz), .pole_cap_code_in(cp),
    .pump_current_code_in(ip), .odiv_sel_in(od), .mode_out(mode), .i2c_sda_out(sda), .i2c_scl_out(scl),
    .output_hold_out(hold), .ref_alternate_out(ralt), .cfg_index_out(idx_o), .mult_out(mul_o),
    .frac_mode_out(fr_o), .ss_enable_out(ss_o), .odiv_out(od_o), .loop_resistor_code_out(rz_o),
    .zero_cap_code_out(cz_o), .pole_cap_code_out(cp_o), .pump_current_code_out(ip_o),
    .zero_cap_dpf_out(zc_o), .pump_ua_out(pu_o));
  always #2 clk_in = ~clk_in;
  // The whole run needs well under a thousand cycles.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Output loop o shows source loop l, configuration c.
  task automatic chk_loop(input int o, input int l, input int c, input logic [2:0] idx);
    logic fr;
    logic [19:0] m;
    fr = (o < 2) && (stp[l][c] != 4'h0) && (dl[l][c] == 48'h0);
    m = (((20'(fbi[l][c]) << 1) + 20'(fba[l][c]) + 20'h0_0001) << 6) + 20'(fr ? fof[l][c] : 6'h00);
    chk("cfg_index", 20'(idx), 20'(idx_o[o]));
    chk("mult", m, mul_o[o]);
    chk("frac_mode", 20'(fr), 20'(fr_o[o]));
    chk("ss_enable", 20'((o < 2) && !fr), 20'(ss_o[o]));
    chk("odiv", 20'(od[l][c]), 20'(od_o[o]));
    chk("codes", {4'h0, rz[l][c], cz[l][c], cp[l][c], 1'b0, ip[l][c]}, {4'h0, rz_o[o], cz_o[o], cp_o[o], 1'b0, ip_o[o]});
    chk("zero_cap", 20'(16'h003C + 16'h0110 * 16'(cz[l][c])), 20'(zc_o[o]));
    chk("pump", 20'(10'h005 << ip[l][c]), 20'(pu_o[o]));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    // Even configurations are fractional, odd ones carry a profile.
    for (int l = 0; l < L; l++) begin
      for (int c = 0; c < C; c++) begin
        fbi[l][c] = 12'h010 + 12'(4 * l + c);
        fba[l][c] = 4'h3;
        fof[l][c] = 6'h30 + 6'(c);
        stp[l][c] = 4'h1;
        dl[l][c] = (c % 2 == 0) ? 48'h0 : 48'h1;
        rz[l][c] = 4'(15 - c);
        cz[l][c] = 4'(5 * l + c);
        cp[l][c] = 4'(c + 1);
        ip[l][c] = 3'(3 * l + c);
        od[l][c] = 1'(c);
      end
    end
    repeat (10) @(negedge clk_in);
    chk("reset_mode", 20'(pcm_pkg::MODE_MFC_ALL), 20'(mode));
    nrst_in = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_in);
      host.set_pins({2'(k + 2), 2'(k + 1), 2'(k)}, 2'h2);
      psel = k[0];
      lock = k[1];
      plost = k[0];
      repeat (6) @(negedge clk_in);
      chk("mode", 20'(pcm_pkg::MODE_MFC_ALL), 20'(mode));
      for (int l = 0; l < L; l++) chk_loop(l, l, (k + l) % 4, 3'((k + l) % 4));
      chk("ref_alt", 20'(k[0]), 20'(ralt));
      chk("out0", 20'(k[1]), 20'(mo0));
      chk("out1", 20'(k[0]), 20'(mo1));
      chk("hold", 20'h0_0000, 20'(hold));
      chk("sda", 20'h0_0001, 20'(sda));
    end
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_in);
      mbit = 1'b1;
      host.set_pins({1'(k >> 1), 1'b0, 1'(k), 3'(k)}, 2'h2);
      repeat (6) @(negedge clk_in);
      chk("mode", 20'(pcm_pkg::MODE_MFC_SINGLE), 20'(mode));
      chk_loop(0, k < 4 ? 0 : k / 2 - 1, k < 4 ? k : 2 + k % 2, 3'(k));
      chk_loop(1, 1, 0, 3'h0);
      chk_loop(2, 2, 0, 3'h0);
      chk("hold", 20'(k[0]), 20'(hold));
      chk("ref_alt", 20'(k[1]), 20'(ralt));
    end
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_in);
      host.set_pins({1'(k), 1'(k), 1'(k >> 1), 1'(k), 1'(k >> 1), 1'(k)}, 2'h1);
      lock = ~k[0];
      repeat (6) @(negedge clk_in);
      chk("mode", 20'(pcm_pkg::MODE_I2C), 20'(mode));
      chk("sda", 20'(k[0]), 20'(sda));
      chk("scl", 20'(k[1]), 20'(scl));
      chk("hold", 20'(k[1]), 20'(hold));
      chk("ref_alt", 20'(k[0]), 20'(ralt));
      chk("out0", 20'(!k[0]), 20'(mo0));
      chk("cfg_index", 20'h0_0000, 20'(idx_o[0]));
    end
    @(negedge clk_in);
    lock = 1'b1;
    plost = 1'b0;
    host.set_pins(6'h10, 2'h0);
    repeat (6) @(negedge clk_in);
    chk("mode", 20'(pcm_pkg::MODE_JTAG), 20'(mode));
    host.scan_frame(8'hA5, seen);
    chk("scan_out", {4'h0, 8'hA5, 8'h02}, {4'h0, seen});
    chk("out1", 20'h0_0000, 20'(mo1));
    // A scan reset pulse must drop the controller out of data shift before the next frame.
    @(negedge clk_in);
    host.set_pins(6'h00, 2'h0);
    lock = 1'b0;
    plost = 1'b1;
    @(negedge clk_in);
    host.set_pins(6'h10, 2'h0);
    repeat (6) @(negedge clk_in);
    host.scan_frame(8'h3C, seen);
    chk("scan_trst", {4'h0, 8'h3C, 8'h01}, {4'h0, seen});
    chk("out1", 20'h0_0001, 20'(mo1));
    final_report();
  end
endmodule
